// ==== rtl/adcctl_top.sv ====
// Sample and conversion control with its APB register file
`include "adcctl_defs.svh"
`default_nettype none
module adcctl_top
	import adcctl_pkg::*;
#(
	parameter int NCH = 4,
	parameter int STW = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic external_irq_pin,
	input wire logic timer_compare,
	output logic [NCH-1:0] hold_sample,
	output logic conv_start,
	output logic [1:0] conv_channel,
	output logic conv_wide,
	input wire logic conv_done,
	input wire logic [11:0] conv_data
);
	adcctl_state_t state_reg;
	adcctl_state_t state_next;

	logic conv_on_reg;
	logic idle_stop_reg;
	logic dma_order_reg;
	logic wide_resolution_select;
	logic [1:0] result_layout;
	logic [2:0] trigger_source_select;
	logic par_hold_reg;
	logic auto_acquire_restart;
	logic done_reg;
	logic done_next;
	logic [1:0] channel_count_select;
	logic ext_fall_reg;
	logic [STW-1:0] sample_time_reg;
	logic [15:0] result_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_status_next;
	logic [1:0] irq_mask_reg;
	logic [1:0] ch_reg;
	logic [1:0] ch_next;
	logic [31:0] prdata_reg;
	logic trig;
	logic missed;
	logic [15:0] formatted;

	// Bus decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire hit_ctrl = (paddr == `ADCCTL_OFF_CTRL);
	wire hit_cfg = (paddr == `ADCCTL_OFF_CFG);
	wire hit_res = (paddr == `ADCCTL_OFF_RESULT);
	wire hit_ists = (paddr == `ADCCTL_OFF_IRQ_STATUS);
	wire hit_imask = (paddr == `ADCCTL_OFF_IRQ_MASK);
	wire hit_sts = (paddr == `ADCCTL_OFF_STATUS);
	wire mapped = hit_ctrl | hit_cfg | hit_res | hit_ists | hit_imask
		| hit_sts;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_cfg = wr & hit_cfg;
	wire wr_ists = wr & hit_ists;
	wire wr_imask = wr & hit_imask;

	// Channel plan
	wire par_hold_eff = par_hold_reg & ~wide_resolution_select
		& (channel_count_select != 2'h0);
	wire [1:0] last_ch;
	assign last_ch = wide_resolution_select ? 2'h0
		: channel_count_select[1] ? 2'h3
		: channel_count_select[0] ? 2'h1 : 2'h0;
	wire last_conv = (ch_reg == last_ch);

	// State and acquire handshake
	wire sampling = (state_reg == ADCCTL_SAMPLE);
	wire acquire_active = sampling;
	wire w_acq = pwdata[`ADCCTL_BIT_ACQ];
	// Writes of one only start sampling from hold, so a busy converter
	// is never disturbed by a stray acquire request
	wire sw_start = wr_ctrl & w_acq & (state_reg == ADCCTL_HOLD);
	wire sw_end = wr_ctrl & ~w_acq;
	wire conv_begin = (state_reg == ADCCTL_START);
	wire conv_end = (state_reg == ADCCTL_WAIT) & conv_done;
	wire restart = auto_acquire_restart & conv_on_reg;
	// A write that switches the converter on may start sampling at once
	wire on_eff = wr_ctrl ? pwdata[`ADCCTL_BIT_ON] : conv_on_reg;

	adcctl_trigger #(
		.STW(STW)
	) u_trigger (
		.pclk(pclk),
		.presetn(presetn),
		.trigger_source_select(trigger_source_select),
		.sampling(sampling),
		.sw_end(sw_end),
		.external_irq_pin(external_irq_pin),
		.ext_falling(ext_fall_reg),
		.timer_compare(timer_compare),
		.sample_time(sample_time_reg),
		.trig(trig),
		.missed(missed)
	);

	adcctl_format u_format (
		.wide(wide_resolution_select),
		.layout(result_layout),
		.raw(conv_data),
		.result(formatted)
	);

	always_comb begin
		state_next = state_reg;
		ch_next = ch_reg;
		case (state_reg)
			ADCCTL_HOLD: begin
				if (on_eff & (sw_start | auto_acquire_restart)) begin
					state_next = ADCCTL_SAMPLE;
				end
			end
			ADCCTL_SAMPLE: begin
				if (trig) begin
					state_next = ADCCTL_START;
					ch_next = 2'h0;
				end
			end
			ADCCTL_START: begin
				state_next = ADCCTL_WAIT;
			end
			ADCCTL_WAIT: begin
				if (conv_done & ~last_conv) begin
					state_next = ADCCTL_START;
					ch_next = ch_reg + 2'h1;
				end else if (conv_done & restart) begin
					state_next = ADCCTL_SAMPLE;
				end else if (conv_done) begin
					state_next = ADCCTL_HOLD;
				end
			end
			default: begin
				state_next = ADCCTL_HOLD;
			end
		endcase
		if (!on_eff) begin
			state_next = ADCCTL_HOLD;
		end
	end

	// Sample/hold gates, one per channel
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_hold
			wire in_plan = (gi <= 32'(last_ch));
			// Sequential mode keeps later channels tracking until
			// their own conversion takes the hold
			wire later = ~par_hold_eff & (gi > 32'(ch_reg))
				& (state_reg != ADCCTL_HOLD);
			assign hold_sample[gi] = conv_on_reg & in_plan
				& (sampling | later);
		end
	endgenerate

	assign conv_start = conv_begin;
	assign conv_channel = ch_reg;
	assign conv_wide = wide_resolution_select;

	// Set wins over every clear of the completion flag
	always_comb begin
		done_next = done_reg;
		if (conv_begin) begin
			done_next = 1'b0;
		end else if (wr_ctrl & ~pwdata[`ADCCTL_BIT_DONE]) begin
			done_next = 1'b0;
		end
		if (conv_end) begin
			done_next = 1'b1;
		end
	end

	always_comb begin
		irq_status_next = irq_status_reg;
		if (wr_ists) begin
			irq_status_next = irq_status_reg & ~pwdata[1:0];
		end
		if (conv_end) begin
			irq_status_next[`ADCCTL_IRQ_DONE] = 1'b1;
		end
		if (missed) begin
			irq_status_next[`ADCCTL_IRQ_MISS] = 1'b1;
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// Readback views
	wire [15:0] ctrl_view = {conv_on_reg, 1'b0, idle_stop_reg,
		dma_order_reg, 1'b0, wide_resolution_select, result_layout,
		trigger_source_select, 1'b0,
		par_hold_reg & ~wide_resolution_select,
		auto_acquire_restart, acquire_active, done_reg};
	wire [15:0] cfg_view = {sample_time_reg, 5'h00, ext_fall_reg,
		channel_count_select};
	wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_view}
		: hit_cfg ? {16'h0000, cfg_view}
		: hit_res ? {16'h0000, result_reg}
		: hit_ists ? {30'h00000000, irq_status_reg}
		: hit_imask ? {30'h00000000, irq_mask_reg}
		: hit_sts ? {29'h00000000, ~(sampling
			| (state_reg == ADCCTL_HOLD)), ch_reg}
		: 32'h00000000;

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ADCCTL_HOLD;
			ch_reg <= 2'h0;
			done_reg <= 1'b0;
			irq_status_reg <= `ADCCTL_RST_IRQ;
			prdata_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			ch_reg <= ch_next;
			done_reg <= done_next;
			irq_status_reg <= irq_status_next;
			if (setup & ~pwrite) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	// Result updates on the same edge as the completion flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= 16'h0000;
		end else if (conv_end) begin
			result_reg <= formatted;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_on_reg <= 1'b0;
			idle_stop_reg <= 1'b0;
			dma_order_reg <= 1'b0;
			wide_resolution_select <= 1'b0;
			result_layout <= `ADCCTL_LAYOUT_INT;
			trigger_source_select <= `ADCCTL_TRIG_SW;
			par_hold_reg <= 1'b0;
			auto_acquire_restart <= 1'b0;
		end else if (wr_ctrl) begin
			conv_on_reg <= pwdata[`ADCCTL_BIT_ON];
			idle_stop_reg <= pwdata[`ADCCTL_BIT_IDLE_STOP];
			dma_order_reg <= pwdata[`ADCCTL_BIT_DMA_ORDER];
			wide_resolution_select <= pwdata[`ADCCTL_BIT_WIDE];
			result_layout <= pwdata[`ADCCTL_BIT_LAYOUT_HI:
				`ADCCTL_BIT_LAYOUT_LO];
			trigger_source_select <= pwdata[`ADCCTL_BIT_TRIG_HI:
				`ADCCTL_BIT_TRIG_LO];
			par_hold_reg <= pwdata[`ADCCTL_BIT_PAR_HOLD];
			auto_acquire_restart <= pwdata[`ADCCTL_BIT_AUTO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_count_select <= `ADCCTL_RST_CHPS;
			ext_fall_reg <= 1'b0;
			sample_time_reg <= STW'(`ADCCTL_RST_STIME);
		end else if (wr_cfg) begin
			channel_count_select <= pwdata[1:0];
			ext_fall_reg <= pwdata[`ADCCTL_BIT_EXT_FALL];
			sample_time_reg <= pwdata[`ADCCTL_BIT_STIME_LO +: STW];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= `ADCCTL_RST_IRQ;
		end else if (wr_imask) begin
			irq_mask_reg <= pwdata[1:0];
		end
	end
endmodule
`default_nettype wire

// ==== rtl/adcctl_defs.svh ====
// Register offsets, field positions, reset values and source and layout codes of the control
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH

`define ADCCTL_OFF_CTRL 8'h00
`define ADCCTL_OFF_CFG 8'h04
`define ADCCTL_OFF_RESULT 8'h08
`define ADCCTL_OFF_IRQ_STATUS 8'h0C
`define ADCCTL_OFF_IRQ_MASK 8'h10
`define ADCCTL_OFF_STATUS 8'h14

`define ADCCTL_BIT_ON 15
`define ADCCTL_BIT_IDLE_STOP 13
`define ADCCTL_BIT_DMA_ORDER 12
`define ADCCTL_BIT_WIDE 10
`define ADCCTL_BIT_LAYOUT_HI 9
`define ADCCTL_BIT_LAYOUT_LO 8
`define ADCCTL_BIT_TRIG_HI 7
`define ADCCTL_BIT_TRIG_LO 5
`define ADCCTL_BIT_PAR_HOLD 3
`define ADCCTL_BIT_AUTO 2
`define ADCCTL_BIT_ACQ 1
`define ADCCTL_BIT_DONE 0

`define ADCCTL_BIT_EXT_FALL 2
`define ADCCTL_BIT_STIME_LO 8
`define ADCCTL_BIT_STIME_HI 15

`define ADCCTL_IRQ_DONE 0
`define ADCCTL_IRQ_MISS 1

`define ADCCTL_TRIG_SW 3'h0
`define ADCCTL_TRIG_EXT 3'h1
`define ADCCTL_TRIG_TIMER 3'h2
`define ADCCTL_TRIG_AUTO 3'h7

`define ADCCTL_LAYOUT_INT 2'h0
`define ADCCTL_LAYOUT_SIGNED 2'h1

`define ADCCTL_RST_CTRL 16'h0000
`define ADCCTL_RST_CHPS 2'h0
`define ADCCTL_RST_STIME 8'h04
`define ADCCTL_RST_IRQ 2'h0

`endif

// ==== rtl/adcctl_pkg.sv ====
// Types shared by the converter control modules
`default_nettype none
package adcctl_pkg;
	typedef enum logic [1:0] {
		ADCCTL_HOLD,
		ADCCTL_SAMPLE,
		ADCCTL_START,
		ADCCTL_WAIT
	} adcctl_state_t;
endpackage
`default_nettype wire

// ==== rtl/adcctl_format.sv ====
// Result layout for 10-bit and 12-bit conversions
`include "adcctl_defs.svh"
`default_nettype none
module adcctl_format
	import adcctl_pkg::*;
(
	input wire logic wide,
	input wire logic [1:0] layout,
	input wire logic [11:0] raw,
	output logic [15:0] result
);
	wire signed_sel = (layout == `ADCCTL_LAYOUT_SIGNED);
	wire [15:0] int10 = {6'h00, raw[9:0]};
	wire [15:0] sgn10 = {{7{~raw[9]}}, raw[8:0]};
	wire [15:0] int12 = {4'h0, raw[11:0]};
	wire [15:0] sgn12 = {{5{~raw[11]}}, raw[10:0]};
	// Reserved layouts fall back to the plain integer form
	assign result = wide ? (signed_sel ? sgn12 : int12)
		: (signed_sel ? sgn10 : int10);
endmodule
`default_nettype wire

// ==== rtl/adcctl_trigger.sv ====
// Trigger selection that ends sampling and starts conversion
`include "adcctl_defs.svh"
`default_nettype none
module adcctl_trigger
	import adcctl_pkg::*;
#(
	parameter int STW = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] trigger_source_select,
	input wire logic sampling,
	input wire logic sw_end,
	input wire logic external_irq_pin,
	input wire logic ext_falling,
	input wire logic timer_compare,
	input wire logic [STW-1:0] sample_time,
	output logic trig,
	output logic missed
);
	logic pin_reg;
	logic [STW-1:0] count_reg;
	logic [STW-1:0] count_next;

	wire pin_rise = external_irq_pin & ~pin_reg;
	wire pin_fall = ~external_irq_pin & pin_reg;
	wire pin_edge = ext_falling ? pin_fall : pin_rise;
	wire count_hit = (count_reg >= sample_time);
	wire sel_sw = (trigger_source_select == `ADCCTL_TRIG_SW);
	wire sel_ext = (trigger_source_select == `ADCCTL_TRIG_EXT);
	wire sel_tmr = (trigger_source_select == `ADCCTL_TRIG_TIMER);
	wire sel_auto = (trigger_source_select == `ADCCTL_TRIG_AUTO);
	// Codes 011 to 110 select nothing, so sampling never triggers and only ends when the converter is switched off
	wire raw_event = (sel_ext & pin_edge)
		| (sel_tmr & timer_compare);

	assign count_next = sampling ? count_reg + {{(STW-1){1'b0}}, 1'b1}
		: '0;
	assign trig = sampling & ((sel_sw & sw_end)
		| raw_event | (sel_auto & count_hit));
	assign missed = ~sampling & raw_event;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_reg <= 1'b0;
			count_reg <= '0;
		end else begin
			pin_reg <= external_irq_pin;
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/adcctl_conv_model.sv ====
// Behavioural converter answering each start after a chosen delay
`default_nettype none
module adcctl_conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input wire logic [7:0] delay,
	input wire logic [11:0] value,
	output logic conv_done,
	output logic [11:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_reg;
	// Data flips every cycle outside done so a stale capture shows up
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_reg <= 8'h00;
			conv_done <= 1'b0;
			conv_data <= 12'hA5A;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_start) begin
				left_reg <= delay;
			end else if (left_reg != 8'h00) begin
				left_reg <= left_reg - 8'h01;
				if (left_reg == 8'h01) begin
					conv_done <= 1'b1;
					conv_data <= value;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/adcctl_monitor.sv ====
// Port assertions for the converter control block
`default_nettype none
module adcctl_monitor #(
	parameter int NCH = 4,
	parameter int STW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [NCH-1:0] hold_sample,
	input wire logic conv_start,
	input wire logic [1:0] conv_channel,
	input wire logic conv_wide,
	input wire logic conv_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_single_conv: assert property (conv_start ##1 !conv_done |=> !conv_start)
		else $error("new start before completion");
	a_track_held: assert property (conv_start |-> !hold_sample[conv_channel])
		else $error("converted channel still tracking");
	a_link_stable: assert property (conv_start |=>
		$stable(conv_channel) && $stable(conv_wide))
		else $error("channel or width moved in conversion");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_unmapped_err: assert property (psel && penable && !pwrite &&
		paddr > 8'h14 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	a_ctrl_zeros: assert property (psel && penable && !pwrite &&
		paddr == 8'h00 |-> prdata[4] == 1'b0)
		else $error("control bit 4 reads one");
	a_wide_nopar: assert property (psel && penable && !pwrite &&
		paddr == 8'h00 && prdata[10] |-> !prdata[3])
		else $error("parallel hold visible in 12-bit mode");
endmodule
`default_nettype wire
bind adcctl_top adcctl_monitor #(.NCH(NCH), .STW(STW)) adcctl_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.hold_sample(hold_sample), .conv_start(conv_start),
	.conv_channel(conv_channel), .conv_wide(conv_wide),
	.conv_done(conv_done));

// ==== testbench/adcctl_top_tb.sv ====
// Self-checking bench for the converter control block
`include "adcctl_defs.svh"
`default_nettype none
module adcctl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic ext_pin = 0, tcmp = 0;
	logic [7:0] paddr = 8'h00, delay = 8'h01;
	logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h00012889;
	logic pready, pslverr, irq, conv_start, conv_wide, conv_done;
	logic [3:0] hold_sample;
	logic [1:0] conv_channel;
	logic [11:0] conv_data, value = 12'h000;
	logic [63:0] notes[$];
	logic [63:0] note;
	int mismatches = 0, n_compared = 0, k;
	always #5 pclk = ~pclk;
	adcctl_top #(.NCH(4), .STW(8)) adcctl_top_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .external_irq_pin(ext_pin),
		.timer_compare(tcmp), .hold_sample(hold_sample),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_wide(conv_wide), .conv_done(conv_done), .conv_data(conv_data));
	adcctl_conv_model adcctl_conv_model_inst (.pclk(pclk), .presetn(presetn),
		.conv_start(conv_start), .delay(delay), .value(value),
		.conv_done(conv_done), .conv_data(conv_data));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [31:0] fmt(logic [11:0] v, logic w, logic [1:0] l);
		if (l != 2'h1) return {20'h0, w ? v : {2'h0, v[9:0]}};
		if (w) return {16'h0, {5{~v[11]}}, v[10:0]};
		return {16'h0, {7{~v[9]}}, v[8:0]};
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task fail;
		mismatches++;
		$display("mismatch at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d | (rnd() & 32'hFFFF0000);
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) fail();
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		notes.push_back({e & m, m});
		apb(0, a, 32'h0);
	endtask
	// Read data is judged mid access phase, away from the clock edge
	always @(negedge pclk) if (psel && penable && !pwrite && pready === 1'b1) begin
		if (notes.size() == 0) fail();
		note = notes.pop_front();
		cmp(prdata & note[31:0], note[63:32]);
	end
	task automatic wsig(input logic dn);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge pclk);
			if ((dn ? conv_done : conv_start) === 1'b1) break;
		end
		if (i >= 3000) fail();
	endtask
	task automatic cv(input logic [15:0] c, input int n);
		int i;
		logic [3:0] act;
		act = n == 4 ? 4'hF : (n == 2 ? 4'h3 : 4'h1);
		value <= 12'(rnd()) & (c[10] ? 12'hFFF : 12'h3FF);
		delay <= c[7:5] == 3'h0 ? 8'h14 : 8'h01 + 8'(rnd() & 32'h7);
		// Bit 0 written as one keeps done, so only a new conversion clears it
		apb(1, `ADCCTL_OFF_CTRL, {16'h0, c | 16'h0001});
		if (c[7:5] == 3'h0)
			apb(1, `ADCCTL_OFF_CTRL, {16'h0, c & 16'hFFFD | 16'h0001});
		if (c[7:5] == 3'h1 || c[7:5] == 3'h2) begin
			repeat (2) @(posedge pclk);
			ext_pin <= c[5];
			tcmp <= c[6];
			@(posedge pclk);
			ext_pin <= 0;
			tcmp <= 0;
		end
		for (i = 0; i < n; i++) begin
			wsig(0);
			cmp({30'h0, conv_channel}, 32'(i));
			cmp({31'h0, conv_wide}, {31'h0, c[10]});
			cmp({28'h0, hold_sample}, c[3] && !c[10] ? 0 : act & (4'hE << i));
			// Clearing done mid conversion must not stop it
			if (c[7:5] == 3'h0) begin
				rd(`ADCCTL_OFF_CTRL, 32'h0, 32'h3);
				apb(1, `ADCCTL_OFF_CTRL, {16'h0, c & 16'hFFFC});
			end
			wsig(1);
		end
		rd(`ADCCTL_OFF_RESULT, fmt(value, c[10], c[9:8]), 32'hFFFF);
		rd(`ADCCTL_OFF_CTRL, {16'h0, c & ~(c[10] ? 16'h000A : 16'h0002)
			| 16'h0001 | (c[2] ? 16'h0002 : 16'h0)}, 32'hFFFF);
		$display("test %h over %0d channels done", c, n);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rd(`ADCCTL_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
		rd(`ADCCTL_OFF_CFG, 32'h0400, 32'hFFFF);
		rd(8'h18, 32'h0, 32'hFFFFFFFF);
		apb(1, `ADCCTL_OFF_CTRL, 32'h0011);
		rd(`ADCCTL_OFF_CTRL, 32'h0, 32'hFFFF);
		for (k = 0; k < 8; k++) cv(16'h80E2 | {5'h0, k[2:0], 8'h0}, 1);
		cv(16'h8042, 1);
		cv(16'h8022, 1);
		cv(16'h8002, 1);
		apb(1, `ADCCTL_OFF_CFG, 32'h0403);
		cv(16'h80EA, 4);
		cv(16'h84EA, 1);
		cv(16'h80E2, 4);
		apb(1, `ADCCTL_OFF_CFG, 32'h0401);
		cv(16'h80EA, 2);
		cv(16'h80E2, 2);
		// Timer source selected while holding, so the pulse is a missed trigger
		apb(1, `ADCCTL_OFF_CTRL, 32'h8041);
		tcmp <= 1;
		@(posedge pclk);
		tcmp <= 0;
		rd(`ADCCTL_OFF_IRQ_STATUS, 32'h3, 32'h3);
		@(negedge pclk) cmp({31'h0, irq}, 32'h0);
		apb(1, `ADCCTL_OFF_IRQ_MASK, 32'h1);
		@(negedge pclk) cmp({31'h0, irq}, 32'h1);
		apb(1, `ADCCTL_OFF_IRQ_STATUS, 32'h3);
		@(negedge pclk) cmp({31'h0, irq}, 32'h0);
		rd(`ADCCTL_OFF_IRQ_STATUS, 32'h0, 32'h3);
		apb(1, `ADCCTL_OFF_CFG, 32'hFF00);
		cv(16'h80E6, 1);
		apb(1, `ADCCTL_OFF_CTRL, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
